/* rtl/wdg_top.sv */
// Watchdog downcounter with halt handling and an AXI4-Lite slave.
// Assumes all inputs synchronous to aclk, which is the oscillator clock.
//
// Functional notes
// RULE1: Software keeps counter_top_bit set on every control write.
// RULE2: Timeout uses 6-bit count; min base (fine+128)*64, max base 16384.
// RULE3: Timebase select picks coarse/fine: 4/59, 8/53, 20/35, 49/54.
// RULE4: Minimum timeout: linear below coarse/4, else stepped formula.
// RULE5: Maximum timeout: same from max base, linear up to coarse/4.
// RULE6: All divisions truncate to integers.
// RULE7: Plain halt: no reset, one decrement, then frozen until wake.
// RULE8: External interrupt ends plain halt; resume after 256/4096 clocks.
// RULE9: Reset ends plain halt into disabled reset state unless hardware option.
// RULE10: Halt with irq enable 0 and halt-reset option 1 resets chip.
// RULE11: Halt with irq enable 1 enters active halt, counter frozen.
// RULE12: Interrupt ends active halt; counting resumes at once.
// RULE13: Reset ends active halt; counting resumes after 256/4096 clocks.
// RULE14: Hardware option makes watchdog always active.
// RULE15: Counter decrements every 16384 cycles, even when disabled.
// RULE16: Active and 40h to 3Fh wrap pulls reset low about 500 ns.
// RULE17: Disabled after any reset; only reset can deactivate.
// RULE18: Prescaler not cleared by writes.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wdg_top #(
  parameter int PRESC_CYCLES = wdg_pkg::PRESC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Options, timebase and core events
  input wire wdg_pkg::wdg_cfg_s cfg,
  input wire wdg_pkg::wdg_evt_s evt,
  input wire logic wake_long,
  // Chip reset request
  output logic wdg_reset_n
);
  localparam int PW = $clog2(PRESC_CYCLES);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_CYCLES - 1);
  localparam logic [12:0] WAKE_S = 13'(wdg_pkg::WAKE_SHORT);
  localparam logic [12:0] WAKE_L = 13'(wdg_pkg::WAKE_LONG);
  localparam logic [4:0] RST_CYC = 5'(wdg_pkg::RST_PULSE_CYC);

  if (PRESC_CYCLES < 2) begin : g_chk
    $error("PRESC_CYCLES must be at least 2");
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  // Free running; writes never touch it, so the first step after a
  // refresh lands anywhere inside one period.
  logic [PW-1:0] presc_reg, presc_next;
  logic tick;
  always_comb begin
    tick = (presc_reg == PRESC_LAST);
    presc_next = tick ? '0 : PW'(presc_reg + 1'b1); // RULE18 RULE15
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_wr, wr_ctrl;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [6:0] cnt_reg;
  logic act_reg;
  wdg_pkg::wdg_mode_e mode_reg;
  logic [wdg_pkg::TOUT_W-1:0] tmin, tmax;

  always_comb begin
    do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
    wr_ctrl = do_wr && wstrb_reg && (awaddr_reg == wdg_pkg::ADDR_CTRL);
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb_next = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == wdg_pkg::ADDR_CTRL) ? wdg_pkg::RESP_OKAY
                                                      : wdg_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next = !w_full_next && !bvalid_next;
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = '0;
    unique case (s_axi_araddr)
      wdg_pkg::ADDR_CTRL: begin
        rd_word[wdg_pkg::ACT_BIT] = act_reg;
        rd_word[6:0] = cnt_reg;
      end
      wdg_pkg::ADDR_STAT: begin
        rd_word[wdg_pkg::STAT_TB_LSB +: 2] = cfg.timebase_select;
        rd_word[wdg_pkg::STAT_IRQEN_BIT] = cfg.timebase_irq_enable;
        rd_word[wdg_pkg::STAT_HOPT_BIT] = cfg.halt_reset_option;
        rd_word[wdg_pkg::STAT_HW_BIT] = cfg.hw_opt;
        rd_word[wdg_pkg::STAT_HALT_BIT] = (mode_reg == wdg_pkg::M_HALT_DEC)
                                          || (mode_reg == wdg_pkg::M_HALT);
        rd_word[wdg_pkg::STAT_AHALT_BIT] = (mode_reg == wdg_pkg::M_AHALT);
        rd_word[wdg_pkg::STAT_WAKE_BIT] = (mode_reg == wdg_pkg::M_WAKE);
      end
      wdg_pkg::ADDR_TMIN: rd_word[wdg_pkg::TOUT_W-1:0] = tmin;
      wdg_pkg::ADDR_TMAX: rd_word[wdg_pkg::TOUT_W-1:0] = tmax;
      default: rd_ok = 1'b0;
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_ok ? wdg_pkg::RESP_OKAY : wdg_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= wdg_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= wdg_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ---------------------------------------------------------------
  // Timeout bounds in oscillator periods
  // ---------------------------------------------------------------
  always_comb begin
    int c, crs, fin, q, step;
    c = int'(cnt_reg[5:0]); // RULE2
    crs = wdg_pkg::COARSE_TB[cfg.timebase_select]; // RULE3
    fin = wdg_pkg::FINE_TB[cfg.timebase_select];
    q = (4 * c) / crs; // RULE6
    step = wdg_pkg::STEP_PERIODS * (c - q)
           + (wdg_pkg::FINE_OFS + fin) * wdg_pkg::BASE_SCALE * q;
    tmin = wdg_pkg::TOUT_W'((fin + wdg_pkg::MIN_BASE_OFS) * wdg_pkg::BASE_SCALE
           + ((c < crs / 4) ? wdg_pkg::STEP_PERIODS * c : step)); // RULE4
    tmax = wdg_pkg::TOUT_W'(wdg_pkg::TMAX0
           + ((c <= crs / 4) ? wdg_pkg::STEP_PERIODS * c : step)); // RULE5
  end

  // ---------------------------------------------------------------
  // Counter, activation and low-power modes
  // ---------------------------------------------------------------
  logic [6:0] cnt_next;
  logic act_next, eff_act, dec, fire, halt_fire;
  wdg_pkg::wdg_mode_e mode_next;
  logic [12:0] wake_reg, wake_next;
  logic [4:0] rst_cnt_reg, rst_cnt_next;
  logic wdg_reset_n_reg, wdg_reset_n_next;

  always_comb begin
    eff_act = act_reg || cfg.hw_opt; // RULE14
    dec = tick && (mode_reg == wdg_pkg::M_RUN || mode_reg == wdg_pkg::M_HALT_DEC);
    cnt_next = dec ? 7'(cnt_reg - 7'h01) : cnt_reg; // RULE15
    act_next = act_reg;
    mode_next = mode_reg;
    wake_next = wake_reg;
    halt_fire = 1'b0;
    // Refresh beats a decrement landing in the same cycle
    if (wr_ctrl) begin
      cnt_next = wdata_reg[6:0];
      act_next = act_reg || wdata_reg[wdg_pkg::ACT_BIT]; // RULE17
    end
    unique case (mode_reg)
      wdg_pkg::M_RUN: begin
        if (evt.halt_req) begin
          if (cfg.timebase_irq_enable) begin
            mode_next = wdg_pkg::M_AHALT; // RULE11
          end else if (cfg.halt_reset_option) begin
            halt_fire = 1'b1; // RULE10
          end else begin
            mode_next = wdg_pkg::M_HALT_DEC; // RULE7
          end
        end
      end
      wdg_pkg::M_HALT_DEC: begin
        if (evt.ext_irq) begin
          mode_next = wdg_pkg::M_WAKE;
          wake_next = wake_long ? WAKE_L : WAKE_S;
        end else if (dec) begin
          mode_next = wdg_pkg::M_HALT; // RULE7
        end
      end
      wdg_pkg::M_HALT: begin
        if (evt.ext_irq) begin
          mode_next = wdg_pkg::M_WAKE; // RULE8
          wake_next = wake_long ? WAKE_L : WAKE_S;
        end
      end
      wdg_pkg::M_AHALT: begin
        if (evt.ext_irq || evt.tb_irq) begin
          mode_next = wdg_pkg::M_RUN; // RULE12
        end
      end
      wdg_pkg::M_WAKE: begin
        wake_next = 13'(wake_reg - 13'h0001);
        if (wake_reg == 13'h0001) begin
          mode_next = wdg_pkg::M_RUN;
        end
      end
      default: mode_next = wdg_pkg::M_RUN;
    endcase
    // Chip reset outranks everything else in this group
    if (evt.sys_rst) begin
      act_next = wdg_pkg::ACT_RST; // RULE17
      cnt_next = wdg_pkg::CNT_RST;
      if (mode_reg == wdg_pkg::M_AHALT) begin
        mode_next = wdg_pkg::M_WAKE; // RULE13
        wake_next = wake_long ? WAKE_L : WAKE_S;
      end else begin
        mode_next = wdg_pkg::M_RUN; // RULE9
      end
    end
    // Wrap past 40h, or a software write clearing the top bit
    fire = !evt.sys_rst && (halt_fire || (eff_act && cnt_reg[wdg_pkg::TOP_BIT]
           && !cnt_next[wdg_pkg::TOP_BIT])); // RULE16 RULE1
    rst_cnt_next = rst_cnt_reg;
    if (fire && rst_cnt_reg == 5'h00) begin
      rst_cnt_next = RST_CYC; // RULE16
    end else if (rst_cnt_reg != 5'h00) begin
      rst_cnt_next = 5'(rst_cnt_reg - 5'h01);
    end
    wdg_reset_n_next = (rst_cnt_next == 5'h00);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= wdg_pkg::CNT_RST;
      act_reg <= wdg_pkg::ACT_RST;
      mode_reg <= wdg_pkg::M_RUN;
      wake_reg <= '0;
      rst_cnt_reg <= '0;
      wdg_reset_n_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      mode_reg <= mode_next;
      wake_reg <= wake_next;
      rst_cnt_reg <= rst_cnt_next;
      wdg_reset_n_reg <= wdg_reset_n_next;
    end
  end

  assign wdg_reset_n = wdg_reset_n_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = !wr_ctrl && !evt.sys_rst;

  property p_expire;
    act_reg && cnt_reg == wdg_pkg::CNT_EXPIRE && dec && quiet && rst_cnt_reg == 5'h00
    |=> !wdg_reset_n ##19 !wdg_reset_n ##1 wdg_reset_n;
  endproperty
  a_expire: assert property (p_expire) else $error("no 500 ns reset on wrap"); // RULE16

  property p_hw;
    !act_reg && cfg.hw_opt && cnt_reg == wdg_pkg::CNT_EXPIRE && dec && quiet
    && rst_cnt_reg == 5'h00 |=> !wdg_reset_n;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware option did not reset"); // RULE14

  property p_free;
    mode_reg == wdg_pkg::M_RUN && tick && quiet |=> cnt_reg == 7'($past(cnt_reg) - 7'h01);
  endproperty
  a_free: assert property (p_free) else $error("counter missed a step"); // RULE15

  property p_halt_stop;
    (mode_reg == wdg_pkg::M_HALT || mode_reg == wdg_pkg::M_AHALT) && quiet
    |=> cnt_reg == $past(cnt_reg) && wdg_reset_n;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("counter moved in halt"); // RULE7

  property p_ahalt;
    mode_reg == wdg_pkg::M_RUN && evt.halt_req && cfg.timebase_irq_enable && !evt.sys_rst
    |=> mode_reg == wdg_pkg::M_AHALT;
  endproperty
  a_ahalt: assert property (p_ahalt) else $error("active halt not entered"); // RULE11

  property p_halt_rst;
    mode_reg == wdg_pkg::M_RUN && evt.halt_req && !cfg.timebase_irq_enable
    && cfg.halt_reset_option && !evt.sys_rst && rst_cnt_reg == 5'h00 |=> !wdg_reset_n;
  endproperty
  a_halt_rst: assert property (p_halt_rst) else $error("halt did not reset"); // RULE10

  property p_ahalt_wake;
    mode_reg == wdg_pkg::M_AHALT && (evt.ext_irq || evt.tb_irq) && !evt.sys_rst
    |=> mode_reg == wdg_pkg::M_RUN;
  endproperty
  a_ahalt_wake: assert property (p_ahalt_wake) else $error("active halt wake late"); // RULE12

  property p_ahalt_rst;
    mode_reg == wdg_pkg::M_AHALT && evt.sys_rst
    |=> mode_reg == wdg_pkg::M_WAKE
        && wake_reg == ($past(wake_long) ? 13'h1000 : 13'h0100);
  endproperty
  a_ahalt_rst: assert property (p_ahalt_rst) else $error("wrong wake delay"); // RULE13

  property p_halt_wake;
    mode_reg == wdg_pkg::M_HALT && evt.ext_irq && !evt.sys_rst && !wake_long
    |=> mode_reg == wdg_pkg::M_WAKE && wake_reg == 13'h0100;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("wrong halt wake"); // RULE8

  property p_rst_clear;
    evt.sys_rst |=> !act_reg && cnt_reg == wdg_pkg::CNT_RST && mode_reg != wdg_pkg::M_HALT;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset kept state"); // RULE9

  property p_tmin;
    cfg.timebase_select == 2'h0 && cnt_reg[5:0] == 6'h00
    |-> tmin == 21'd11968 && tmax == 21'd16384;
  endproperty
  a_tmin: assert property (p_tmin) else $error("bad base timeout"); // RULE4

  property p_tmax;
    cfg.timebase_select == 2'h0 && cnt_reg[5:0] == 6'h3f
    |-> tmin == 21'd1024000 && tmax == 21'd1028416;
  endproperty
  a_tmax: assert property (p_tmax) else $error("bad full timeout"); // RULE5

  property p_presc;
    wr_ctrl && !tick |=> presc_reg == PW'($past(presc_reg) + 1'b1);
  endproperty
  a_presc: assert property (p_presc) else $error("write moved prescaler"); // RULE18

  c_fire: cover property ($fell(wdg_reset_n));
  c_ahalt: cover property (mode_reg == wdg_pkg::M_AHALT ##1 mode_reg == wdg_pkg::M_RUN);
  c_wake: cover property (mode_reg == wdg_pkg::M_WAKE ##1 mode_reg == wdg_pkg::M_RUN);
endmodule // wdg_top

/* rtl/wdg_pkg.sv */
// Package: constants, modes and carriers of the watchdog block.
// Assumes aclk is the oscillator clock at 40 MHz.
package wdg_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TMIN = 8'h08;
  localparam logic [7:0] ADDR_TMAX = 8'h0c;
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [6:0] CNT_RST = 7'h7f;
  localparam logic [6:0] CNT_EXPIRE = 7'h40;
  localparam logic ACT_RST = 1'b0;
  localparam int STAT_TB_LSB = 0;
  localparam int STAT_IRQEN_BIT = 2;
  localparam int STAT_HOPT_BIT = 3;
  localparam int STAT_HW_BIT = 4;
  localparam int STAT_HALT_BIT = 5;
  localparam int STAT_AHALT_BIT = 6;
  localparam int STAT_WAKE_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYC = RST_PULSE_NS * CLK_MHZ / 1000;
  localparam int PRESC_DEF = 16384;
  localparam int WAKE_SHORT = 256;
  localparam int WAKE_LONG = 4096;
  // ---------------------------------------------------------------
  // Timeout formula
  // ---------------------------------------------------------------
  localparam int MIN_BASE_OFS = 128;
  localparam int BASE_SCALE = 64;
  localparam int TMAX0 = 16384;
  localparam int STEP_PERIODS = 16384;
  localparam int FINE_OFS = 192;
  localparam int COARSE_TB [4] = '{4, 8, 20, 49};
  localparam int FINE_TB [4] = '{59, 53, 35, 54};
  localparam int TOUT_W = 21;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {M_RUN, M_HALT_DEC, M_HALT, M_AHALT, M_WAKE} wdg_mode_e;
  typedef struct packed {
    logic hw_opt;
    logic halt_reset_option;
    logic timebase_irq_enable;
    logic [1:0] timebase_select;
  } wdg_cfg_s;
  typedef struct packed {
    logic halt_req;
    logic ext_irq;
    logic tb_irq;
    logic sys_rst;
  } wdg_evt_s;
endpackage

/* tb/tb.sv */
// Testbench for the watchdog block: AXI4-Lite tasks and directed sequences.
// Assumes wdg_top with a shortened prescaler; inputs change after rising edges.
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int PR = 16;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake_long, wdg_reset_n;
  wdg_pkg::wdg_cfg_s cfg;
  wdg_pkg::wdg_evt_s evt;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n_fall = 0, run = 0, last_len = 0, nf, d;
  int cl [6] = '{0, 1, 2, 5, 12, 63};
  logic prev_n = 1'b1;
  logic [31:0] rd, v0, v1;
  logic [1:0] rsp;

  wdg_top #(.PRESC_CYCLES(PR)) wdg_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg, .evt, .wake_long, .wdg_reset_n);

  always #12.5 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Monitors and closing
  // ---------------------------------------------------------------
  // A run of about 6000 cycles is expected; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Counts reset requests and measures the length of each low pulse
  always @(posedge aclk) begin
    if (prev_n && !wdg_reset_n) n_fall++;
    if (!wdg_reset_n) run++;
    else if (!prev_n) begin
      last_len = run;
      run = 0;
    end
    prev_n = wdg_reset_n;
  end

  task automatic conclude();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus and event tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic awp, wp;
    awp = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (awp || wp) begin
      @(posedge aclk);
      if (awp && s_axi_awready) begin
        awp = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic arp;
    arp = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arp && s_axi_arready) begin
        arp = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Event order: halt_req 8, ext_irq 4, tb_irq 2, sys_rst 1
  task automatic pulse(input logic [3:0] e);
    @(posedge aclk);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // The fall count is taken before the cause, since a firing can beat the bus answer
  task automatic wait_fire(input int n0, input int lim);
    for (int i = 0; i < lim && n_fall == n0; i++) @(posedge aclk);
    repeat (wdg_pkg::RST_PULSE_CYC + 4) @(posedge aclk);
    chk(n_fall - n0, 1);
    chk(last_len, wdg_pkg::RST_PULSE_CYC);
  endtask

  function automatic int tout(input int s, input int cn, input bit mx);
    int c, f, q, b;
    c = wdg_pkg::COARSE_TB[s];
    f = wdg_pkg::FINE_TB[s];
    q = 4 * cn / c;
    b = mx ? 16384 : (f + 128) * 64;
    if (mx ? cn <= c / 4 : cn < c / 4) return b + 16384 * cn;
    return b + 16384 * (cn - q) + (192 + f) * 64 * q;
  endfunction

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    cfg = 5'h0a;
    evt = '0;
    wake_long = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd, 32'h7f);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd, 32'h0a);
    wr(wdg_pkg::ADDR_STAT, 32'h5a);
    chk(rsp, wdg_pkg::RESP_SLVERR);
    rd_reg(8'h10);
    chk(rsp, wdg_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    cfg <= 5'h00;
    nf = n_fall;
    wr(wdg_pkg::ADDR_CTRL, 32'h41);
    idle(4 * PR);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(n_fall - nf, 0);
    chk(rd < 32'h3f && rd > 32'h3a, 1);
    for (int w = 0; w < 2; w++) begin
      wake_long <= w[0];
      wr(wdg_pkg::ADDR_CTRL, 32'h7f);
      rd_reg(wdg_pkg::ADDR_CTRL);
      v0 = rd;
      pulse(4'h8);
      idle(3 * PR);
      rd_reg(wdg_pkg::ADDR_CTRL);
      v1 = rd;
      chk(v0 - v1 == 1 || v0 - v1 == 2, 1);
      rd_reg(wdg_pkg::ADDR_STAT);
      chk(rd[5], 1);
      idle(4 * PR);
      rd_reg(wdg_pkg::ADDR_CTRL);
      chk(rd, v1);
      d = w ? wdg_pkg::WAKE_LONG : wdg_pkg::WAKE_SHORT;
      pulse(4'h4);
      idle(d - 40);
      rd_reg(wdg_pkg::ADDR_STAT);
      chk(rd[7], 1);
      idle(60);
      rd_reg(wdg_pkg::ADDR_STAT);
      chk(rd[7:5], 0);
    end
    wake_long <= 1'b0;
    cfg <= 5'h04;
    pulse(4'h8);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[6], 1);
    // Counter is frozen here, so the timeout reads cannot drift between write and read
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 6; k++) begin
        cfg <= 5'h04 | 5'(s);
        wr(wdg_pkg::ADDR_CTRL, 32'h40 | 32'(cl[k]));
        rd_reg(wdg_pkg::ADDR_TMIN);
        chk(rd, tout(s, cl[k], 1'b0));
        rd_reg(wdg_pkg::ADDR_TMAX);
        chk(rd, tout(s, cl[k], 1'b1));
      end
    end
    rd_reg(wdg_pkg::ADDR_CTRL);
    v0 = rd;
    idle(3 * PR);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd, v0);
    pulse(4'h2);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[7:6], 0);
    idle(2 * PR);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd < v0, 1);
    pulse(4'h8);
    pulse(4'h1);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[7:6], 2'b10);
    idle(300);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[7:6], 0);
    // Plain halt with the watchdog active, then ended by a chip reset
    wr(wdg_pkg::ADDR_CTRL, 32'hff);
    cfg <= 5'h00;
    pulse(4'h8);
    idle(2 * PR);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[5], 1);
    pulse(4'h1);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd[7], 0);
    rd_reg(wdg_pkg::ADDR_STAT);
    chk(rd[7:5], 0);
    cfg <= 5'h00;
    nf = n_fall;
    wr(wdg_pkg::ADDR_CTRL, 32'hc2);
    wait_fire(nf, 4 * PR);
    wr(wdg_pkg::ADDR_CTRL, 32'h7f);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd[7], 1);
    pulse(4'h1);
    rd_reg(wdg_pkg::ADDR_CTRL);
    chk(rd[7], 0);
    wr(wdg_pkg::ADDR_CTRL, 32'hff);
    nf = n_fall;
    wr(wdg_pkg::ADDR_CTRL, 32'hbf);
    wait_fire(nf, 8);
    cfg <= 5'h08;
    nf = n_fall;
    pulse(4'h8);
    wait_fire(nf, 8);
    pulse(4'h1);
    cfg <= 5'h10;
    nf = n_fall;
    wr(wdg_pkg::ADDR_CTRL, 32'h42);
    wait_fire(nf, 4 * PR);
    conclude();
  end
endmodule // tb
